// >>> core/clgc_pkg.sv
// constants shared by the codec link global control block
package clgc_pkg;
    // io register offsets, relative to io_base_address
    localparam logic [7:0] LINK_GLOBAL_CONTROL_OFS = 8'h3c;
    localparam logic [7:0] LINK_GLOBAL_STATUS_OFS = 8'h40;
    // reset values
    localparam logic [31:0] LINK_GLOBAL_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] LINK_GLOBAL_STATUS_RST = 32'h0000_0000;
    // control field positions
    localparam int CTL_INPUT_CHANGE_IRQ_EN_BIT = 0;
    localparam int CTL_COLD_RESET_N_BIT = 1;
    localparam int CTL_WARM_RESET_BIT = 2;
    localparam int CTL_SHUT_OFF_BIT = 3;
    localparam int CTL_PRI_RESUME_IRQ_EN_BIT = 4;
    localparam int CTL_SEC_RESUME_IRQ_EN_BIT = 5;
    localparam int CTL_WIDTH = 6;
    // status field positions
    localparam int STA_INPUT_CHANGE_BIT = 0;
    localparam int STA_PRI_RESUME_BIT = 10;
    localparam int STA_SEC_RESUME_BIT = 11;
    // timing, figures in ns and the core clock period
    localparam int CORE_CLK_PERIOD_NS = 40;
    localparam int WARM_PULSE_NS = 1000;
    localparam int BCLK_IDLE_NS = 1000;
    // least times round up
    localparam int WARM_PULSE_CYC = (WARM_PULSE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int BCLK_IDLE_CYC = (BCLK_IDLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int CNT_WIDTH = 8;
    // warm reset sequencer states
    typedef enum logic [1:0] {
        CLGC_WARM_IDLE,
        CLGC_WARM_PULSE,
        CLGC_WARM_WAIT_CLK
    } clgc_warm_state_t;
endpackage

// >>> core/clgc_sync3.sv
// three flop synchroniser whose output moves once stages two and three agree
`timescale 1ns/10ps
module clgc_sync3 #(
    parameter int WIDTH = 1
) (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // asynchronous input and filtered output
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

    ////////////////////////////////////////////////////////////////////////
    // next values; s1 is read only by s2 to keep metastability contained
    always_comb begin
        s1_d = async_i;
        s2_d = s1_q;
        s3_d = s2_q;
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // registers, frozen while ce_i is low
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else if (ce_i) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;
endmodule // clgc_sync3

// >>> core/clgc_top.sv
// global control of the codec serial link: control word, status, resets
`timescale 1ns/10ps
module clgc_top (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // io register port, single cycle strobes
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [3:0] io_be_i,
    input wire logic [31:0] io_wdata_i,
    output logic [31:0] io_rdata_o,
    // system events on the core clock
    input wire logic sleep_entry_i,
    input wire logic slot12_valid_i,
    input wire logic slot12_bit0_i,
    input wire logic frame_sync_i,
    input wire logic frame_sdata_out_i,
    // link pins
    input wire logic bit_clk_i,
    input wire logic primary_codec_serial_in_i,
    input wire logic secondary_codec_serial_in_i,
    output logic link_cold_reset_n_o,
    output logic link_sync_o,
    output logic link_sdata_out_o,
    output logic link_input_enable_o,
    // interrupt request
    output logic irq_o
);
    // released reset copy
    logic rst_s1_q, rst_n;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronised link inputs: bit clock, primary and secondary data
    logic [2:0] pin_sync;
    clgc_sync3 #(.WIDTH(3)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .async_i({secondary_codec_serial_in_i, primary_codec_serial_in_i, bit_clk_i}),
        .sync_o(pin_sync)
    );

    // state
    logic [clgc_pkg::CTL_WIDTH-1:0] ctrl_q, ctrl_d; // control word
    logic sta_gpi_q, sta_gpi_d; // input change status
    logic sta_pri_q, sta_pri_d; // primary resume status
    logic sta_sec_q, sta_sec_d; // secondary resume status
    clgc_pkg::clgc_warm_state_t warm_q, warm_d; // warm reset sequencer
    logic [clgc_pkg::CNT_WIDTH-1:0] cnt_q, cnt_d; // warm pulse length
    logic [clgc_pkg::CNT_WIDTH-1:0] idle_q, idle_d; // cycles since bit clock edge
    logic [2:0] prev_q, prev_d; // last gated input levels
    logic [31:0] rdata_d;
    logic cold_n_d, sync_d, sdo_d, inen_d, irq_d;

    // decoded strobes and gated inputs
    logic shut_off, bclk_run, wr_ctl, wr_sta, rd_ctl, rd_sta;
    logic [2:0] gated;
    logic pri_rise, sec_rise;

    always_comb begin
        shut_off = ctrl_q[clgc_pkg::CTL_SHUT_OFF_BIT];
        gated = shut_off ? 3'h0 : pin_sync;
        bclk_run = (idle_q < clgc_pkg::CNT_WIDTH'(clgc_pkg::BCLK_IDLE_CYC));
        // resume is a rising data line while the bit clock is absent
        pri_rise = gated[1] && !prev_q[1] && !bclk_run;
        sec_rise = gated[2] && !prev_q[2] && !bclk_run;
        wr_ctl = 1'b0;
        wr_sta = 1'b0;
        rd_ctl = 1'b0;
        rd_sta = 1'b0;
        if (io_addr_i == clgc_pkg::LINK_GLOBAL_CONTROL_OFS) begin
            wr_ctl = io_wr_i && io_be_i[0];
            rd_ctl = io_rd_i;
        end else if (io_addr_i == clgc_pkg::LINK_GLOBAL_STATUS_OFS) begin
            wr_sta = io_wr_i;
            rd_sta = io_rd_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of control, status and warm reset sequencer
    always_comb begin
        ctrl_d = ctrl_q;
        sta_gpi_d = sta_gpi_q;
        sta_pri_d = sta_pri_q;
        sta_sec_d = sta_sec_q;
        warm_d = warm_q;
        cnt_d = cnt_q;
        prev_d = gated;
        // bit clock activity counter saturates at the idle figure
        if (gated[0] != prev_q[0]) begin
            idle_d = '0;
        end else if (bclk_run) begin
            idle_d = idle_q + 8'h01;
        end else begin
            idle_d = idle_q;
        end
        // software write of the control word
        if (wr_ctl) begin
            ctrl_d[0] = io_wdata_i[0];
            ctrl_d[1] = io_wdata_i[1];
            ctrl_d[5:3] = io_wdata_i[5:3];
            // bit 2 is taken by the sequencer below, only when idle
        end
        // sleep entry overrides software; bus reset handled by reset
        if (sleep_entry_i) begin
            ctrl_d[1] = 1'b0;
        end
        // warm reset sequence
        case (warm_q)
            clgc_pkg::CLGC_WARM_IDLE: begin
                // start lives here so the idle branch cannot undo it
                if (wr_ctl && io_wdata_i[2] && !bclk_run) begin
                    ctrl_d[2] = 1'b1;
                    warm_d = clgc_pkg::CLGC_WARM_PULSE;
                    cnt_d = '0;
                end
            end
            clgc_pkg::CLGC_WARM_PULSE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == clgc_pkg::CNT_WIDTH'(clgc_pkg::WARM_PULSE_CYC - 1)) begin
                    warm_d = clgc_pkg::CLGC_WARM_WAIT_CLK;
                end
            end
            clgc_pkg::CLGC_WARM_WAIT_CLK: begin
                // self clear once the codec clock is back
                if (bclk_run) begin
                    ctrl_d[2] = 1'b0;
                    warm_d = clgc_pkg::CLGC_WARM_IDLE;
                end
            end
            default: begin
                warm_d = clgc_pkg::CLGC_WARM_IDLE;
            end
        endcase
        // write one to clear, a same cycle event wins
        if (wr_sta && io_be_i[0] && io_wdata_i[clgc_pkg::STA_INPUT_CHANGE_BIT]) begin
            sta_gpi_d = 1'b0;
        end
        if (wr_sta && io_be_i[1] && io_wdata_i[clgc_pkg::STA_PRI_RESUME_BIT]) begin
            sta_pri_d = 1'b0;
        end
        if (wr_sta && io_be_i[1] && io_wdata_i[clgc_pkg::STA_SEC_RESUME_BIT]) begin
            sta_sec_d = 1'b0;
        end
        if (slot12_valid_i && slot12_bit0_i && !shut_off) begin
            sta_gpi_d = 1'b1;
        end
        if (pri_rise) begin
            sta_pri_d = 1'b1;
        end
        if (sec_rise) begin
            sta_sec_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output flops: pins, read data, interrupt
    always_comb begin
        cold_n_d = ctrl_q[clgc_pkg::CTL_COLD_RESET_N_BIT] && !shut_off;
        sync_d = !shut_off && ((warm_q == clgc_pkg::CLGC_WARM_PULSE) || frame_sync_i);
        sdo_d = !shut_off && frame_sdata_out_i;
        inen_d = !shut_off;
        irq_d = (sta_sec_q && ctrl_q[clgc_pkg::CTL_SEC_RESUME_IRQ_EN_BIT])
            || (sta_pri_q && ctrl_q[clgc_pkg::CTL_PRI_RESUME_IRQ_EN_BIT])
            || (sta_gpi_q && ctrl_q[clgc_pkg::CTL_INPUT_CHANGE_IRQ_EN_BIT]);
        rdata_d = io_rdata_o;
        if (rd_ctl) begin
            rdata_d = 32'h0000_0000;
            rdata_d[clgc_pkg::CTL_WIDTH-1:0] = ctrl_q;
            rdata_d[clgc_pkg::CTL_COLD_RESET_N_BIT] = link_cold_reset_n_o;
        end else if (rd_sta) begin
            rdata_d = 32'h0000_0000;
            rdata_d[clgc_pkg::STA_INPUT_CHANGE_BIT] = sta_gpi_q;
            rdata_d[clgc_pkg::STA_PRI_RESUME_BIT] = sta_pri_q;
            rdata_d[clgc_pkg::STA_SEC_RESUME_BIT] = sta_sec_q;
        end else if (io_rd_i) begin
            rdata_d = 32'h0000_0000; // unmapped reads as zero
        end
    end

    // registers, all frozen while ce_i is low
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= clgc_pkg::LINK_GLOBAL_CONTROL_RST[clgc_pkg::CTL_WIDTH-1:0];
            sta_gpi_q <= clgc_pkg::LINK_GLOBAL_STATUS_RST[clgc_pkg::STA_INPUT_CHANGE_BIT];
            sta_pri_q <= clgc_pkg::LINK_GLOBAL_STATUS_RST[clgc_pkg::STA_PRI_RESUME_BIT];
            sta_sec_q <= clgc_pkg::LINK_GLOBAL_STATUS_RST[clgc_pkg::STA_SEC_RESUME_BIT];
            warm_q <= clgc_pkg::CLGC_WARM_IDLE;
            cnt_q <= '0;
            idle_q <= clgc_pkg::CNT_WIDTH'(clgc_pkg::BCLK_IDLE_CYC);
            prev_q <= '0;
            io_rdata_o <= 32'h0000_0000;
            link_cold_reset_n_o <= 1'b0;
            link_sync_o <= 1'b0;
            link_sdata_out_o <= 1'b0;
            link_input_enable_o <= 1'b0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            sta_gpi_q <= sta_gpi_d;
            sta_pri_q <= sta_pri_d;
            sta_sec_q <= sta_sec_d;
            warm_q <= warm_d;
            cnt_q <= cnt_d;
            idle_q <= idle_d;
            prev_q <= prev_d;
            io_rdata_o <= rdata_d;
            link_cold_reset_n_o <= cold_n_d;
            link_sync_o <= sync_d;
            link_sdata_out_o <= sdo_d;
            link_input_enable_o <= inen_d;
            irq_o <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the block's own outputs and state
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n || !ce_i);

    AST_SEC_RESUME_IRQ: assert property (
        sta_sec_q && ctrl_q[5] |=> irq_o) else $error("secondary resume irq missing");
    AST_PRI_RESUME_IRQ: assert property (
        sta_pri_q && ctrl_q[4] |=> irq_o) else $error("primary resume irq missing");
    AST_SHUT_OFF_LOW: assert property (
        ctrl_q[3] |=> !link_sync_o && !link_sdata_out_o && !link_cold_reset_n_o
        && !link_input_enable_o) else $error("link driven during shut-off");
    AST_WARM_START: assert property (
        wr_ctl && io_wdata_i[2] && !bclk_run && warm_q == clgc_pkg::CLGC_WARM_IDLE
        && !sleep_entry_i |=> ctrl_q[2] ##1 (link_sync_o || shut_off))
        else $error("warm reset did not start");
    AST_WARM_IGNORED: assert property (
        wr_ctl && io_wdata_i[2] && bclk_run && !ctrl_q[2] |=> !ctrl_q[2])
        else $error("warm write taken with clock running");
    AST_WARM_CLEARS: assert property (
        warm_q == clgc_pkg::CLGC_WARM_WAIT_CLK && bclk_run |=> !ctrl_q[2])
        else $error("warm bit did not self clear");
    AST_COLD_WRITE: assert property (
        wr_ctl && !io_wdata_i[1] |=> !ctrl_q[1] ##1 !link_cold_reset_n_o)
        else $error("cold reset not asserted");
    AST_COLD_READ: assert property (
        rd_ctl |=> io_rdata_o[1] == $past(link_cold_reset_n_o))
        else $error("cold bit read differs from pin");
    AST_SLEEP_COLD: assert property (
        sleep_entry_i |=> !ctrl_q[1] ##1 !link_cold_reset_n_o)
        else $error("sleep did not clear cold bit");
    AST_GPI_SET: assert property (
        slot12_valid_i && slot12_bit0_i && !shut_off |=> sta_gpi_q)
        else $error("input change status not set");
    AST_PRI_SET: assert property (
        pri_rise |=> sta_pri_q) else $error("primary resume status not set");
    AST_NO_IRQ: assert property (
        ctrl_q[5:4] == 2'b00 && !ctrl_q[0] |=> !irq_o) else $error("irq without enable");

    COV_WARM_DONE: cover property (warm_q == clgc_pkg::CLGC_WARM_WAIT_CLK ##[1:200] !ctrl_q[2]);
    COV_PRI_IRQ: cover property (pri_rise ##1 sta_pri_q ##[1:4] irq_o);
    COV_GPI_IRQ: cover property (slot12_valid_i && slot12_bit0_i ##[1:4] irq_o);
    COV_SHUT_OFF: cover property (wr_ctl && io_wdata_i[3] ##2 !link_input_enable_o);
endmodule // clgc_top

// >>> test/clgc_codec_model.sv
// behavioural codec pair standing on the far side of the serial link
`timescale 1ns/10ps
module clgc_codec_model #(
    parameter int WAKE_DELAY_NS = 2000
) (
    // link pins seen from the codec side
    input wire logic cold_reset_n_i,
    input wire logic sync_i,
    output logic bit_clk_o,
    output logic pri_sdin_o,
    output logic sec_sdin_o,
    // bench commands
    input wire logic suspend_i,
    input wire logic wake_pri_i,
    input wire logic wake_sec_i
);
    logic run_q; // bit clock running
    ////////////////////////////////////////////////////////////////////////////////
    // bit clock, 320 ns, stands still low outside activity
    initial begin
        run_q = 1'b0;
        bit_clk_o = 1'b0;
        forever begin
            if (run_q) begin
                #160 bit_clk_o = ~bit_clk_o;
            end else begin
                bit_clk_o = 1'b0;
                @(run_q);
            end
        end
    end
    // cold reset or a power-down request stops the clock at once
    always @(negedge cold_reset_n_i or posedge suspend_i) run_q = 1'b0;
    // codec comes up slowly after cold release
    always @(posedge cold_reset_n_i) begin
        #(WAKE_DELAY_NS);
        if (cold_reset_n_i) run_q = 1'b1;
    end
    // end of a sync pulse wakes a suspended codec, registers kept
    always @(negedge sync_i) begin
        if (!run_q && cold_reset_n_i) #(WAKE_DELAY_NS) run_q = 1'b1;
    end
    // resume is a rising data line while the clock is absent
    assign pri_sdin_o = wake_pri_i;
    assign sec_sdin_o = wake_sec_i;
endmodule // clgc_codec_model

// >>> test/clgc_top_tb.sv
// self-checking bench for the codec link global control block
`timescale 1ns/10ps
module clgc_top_tb;
    logic clk, rst_n, wr, rd, sleep, s12_v, s12_b, fsync, fdata, susp, wk_p, wk_s;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    logic bclk, sd_p, sd_s, cold_n, sync, sdo, in_en, irq, ce;
    logic [31:0] rdata_w; // polled control word
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            print_verdict();
        end
    end
    clgc_top i_clgc_top (.core_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .io_wr_i(wr),
        .io_rd_i(rd), .io_addr_i(addr), .io_be_i(be), .io_wdata_i(wdata), .io_rdata_o(rdata),
        .sleep_entry_i(sleep), .slot12_valid_i(s12_v), .slot12_bit0_i(s12_b),
        .frame_sync_i(fsync), .frame_sdata_out_i(fdata), .bit_clk_i(bclk),
        .primary_codec_serial_in_i(sd_p), .secondary_codec_serial_in_i(sd_s),
        .link_cold_reset_n_o(cold_n), .link_sync_o(sync), .link_sdata_out_o(sdo),
        .link_input_enable_o(in_en), .irq_o(irq));
    clgc_codec_model i_clgc_codec_model (.cold_reset_n_i(cold_n), .sync_i(sync),
        .bit_clk_o(bclk), .pri_sdin_o(sd_p), .sec_sdin_o(sd_s), .suspend_i(susp),
        .wake_pri_i(wk_p), .wake_sec_i(wk_s));
    ////////////////////////////////////////////////////////////////////////////////
    // helpers, entered and left at a falling edge, save print_verdict when the hang guard calls it at a rising edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(2);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic wctl(input logic [31:0] d);
        wr_reg(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, d);
    endtask
    task automatic wsta(input logic [31:0] d);
        wr_reg(clgc_pkg::LINK_GLOBAL_STATUS_OFS, d);
    endtask
    // power the codec down and let the clock-absent window pass
    task automatic stop_codec();
        susp = 1'b1;
        cyc(1);
        susp = 1'b0;
        cyc(40);
    endtask
    // one resume event from either codec, with or without its enable
    task automatic resume_case(input bit sec, input bit en);
        logic [31:0] st;
        st = sec ? 32'h0000_0800 : 32'h0000_0400;
        wctl(en ? (sec ? 32'h0000_0022 : 32'h0000_0012) : 32'h0000_0002);
        if (sec) wk_s = 1'b1;
        else wk_p = 1'b1;
        cyc(10);
        wk_p = 1'b0;
        wk_s = 1'b0;
        rd_chk(clgc_pkg::LINK_GLOBAL_STATUS_OFS, st);
        chk(irq, en);
        wsta(st);
        rd_chk(clgc_pkg::LINK_GLOBAL_STATUS_OFS, 32'h0000_0000);
        chk(irq, 1'b0);
    endtask
    // one slot 12 report, bit 0 given
    task automatic slot12(input logic b, input logic [31:0] ctl);
        wctl(ctl);
        s12_v = 1'b1;
        s12_b = b;
        cyc(1);
        s12_v = 1'b0;
        cyc(3);
        rd_chk(clgc_pkg::LINK_GLOBAL_STATUS_OFS, {31'h0, b});
        chk(irq, b & ctl[0]);
        wsta(32'h0000_0001);
        rd_chk(clgc_pkg::LINK_GLOBAL_STATUS_OFS, 32'h0000_0000);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {wr, rd, sleep, s12_v, s12_b, fsync, fdata, susp, wk_p, wk_s} = '0;
        addr = 8'h00;
        ce = 1'b1;
        be = 4'hf;
        wdata = 32'h0000_0000;
        rst_n = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        cyc(4);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, clgc_pkg::LINK_GLOBAL_CONTROL_RST);
        rd_chk(clgc_pkg::LINK_GLOBAL_STATUS_OFS, clgc_pkg::LINK_GLOBAL_STATUS_RST);
        rd_chk(8'h10, 32'h0000_0000);
        chk(cold_n, 1'b0);
        $display("test reset values done");
        // release cold reset; codec clock comes up, so warm write is dropped
        wctl(32'h0000_0002);
        chk(cold_n, 1'b1);
        cyc(80);
        wctl(32'h0000_0006);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0002);
        chk(sync, 1'b0);
        // warm reset with the clock absent
        stop_codec();
        wctl(32'h0000_0006);
        chk(sync, 1'b1);
        cyc(30);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0006);
        repeat (300) begin
            rd_reg(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, rdata_w);
            if (rdata_w[2] === 1'b0) break;
        end
        chk(rdata_w, 32'h0000_0002);
        $display("test warm reset done");
        stop_codec();
        for (int i = 0; i < 4; i++) resume_case(i[1], i[0]);
        $display("test resume done");
        slot12(1'b1, 32'h0000_0002);
        slot12(1'b1, 32'h0000_0003);
        slot12(1'b0, 32'h0000_0003);
        $display("test input change done");
        // frame traffic passes until the link is shut off
        fsync = 1'b1;
        fdata = 1'b1;
        cyc(3);
        chk({sync, sdo, in_en}, 3'b111);
        wctl(32'h0000_000a);
        cyc(1);
        chk({cold_n, sync, sdo, in_en}, 4'b0000);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0008);
        fsync = 1'b0;
        fdata = 1'b0;
        wctl(32'h0000_0002);
        $display("test shut off done");
        // cold reset, held over a microsecond before release
        wctl(32'h0000_0000);
        chk(cold_n, 1'b0);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0000);
        cyc(30);
        wctl(32'h0000_0002);
        chk(cold_n, 1'b1);
        // a write while the enable is low must not land
        ce = 1'b0;
        wctl(32'h0000_0000);
        ce = 1'b1;
        chk(cold_n, 1'b1);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0002);
        sleep = 1'b1;
        cyc(1);
        sleep = 1'b0;
        cyc(2);
        chk(cold_n, 1'b0);
        rd_chk(clgc_pkg::LINK_GLOBAL_CONTROL_OFS, 32'h0000_0000);
        $display("test cold reset done");
        print_verdict();
    end
endmodule // clgc_top_tb
